// *** shared/rcf_pkg.sv ***
// constants and state types for the century and status-flags register block
//
// Summary of operation
// - century held as two BCD digits, 0-99
// - power fail flag sets below switch threshold
// - flags read or power-up clears power fail
// - write-freeze release loads counters after transfer period
// - match-select 0 compares field, 1 ignores it
package rcf_pkg;

  // apb geometry: printed offsets are word indexes
  localparam int unsigned      PADDR_W     = 17;
  localparam logic [15:0]      IDX_FLAGS   = 16'h7FF0;
  localparam logic [15:0]      IDX_CENTURY = 16'h7FF1;
  localparam logic [16:0]      ADDR_FLAGS  = {1'b0, IDX_FLAGS} << 2;
  localparam logic [16:0]      ADDR_CENT   = {1'b0, IDX_CENTURY} << 2;

  // status-flags field positions
  localparam int unsigned      FLG_WDOG    = 7;
  localparam int unsigned      FLG_ALARM   = 6;
  localparam int unsigned      FLG_PWRFAIL = 5;
  localparam int unsigned      FLG_OSCFAIL = 4;
  localparam int unsigned      FLG_CAL     = 2;
  localparam int unsigned      FLG_WFRZ    = 1;
  localparam int unsigned      FLG_RFRZ    = 0;

  // reset values
  localparam logic [7:0]       CENTURY_RST = 8'h00;
  localparam logic             CTRL_RST    = 1'b0;

  // alarm field layout
  localparam int unsigned      ALM_MSEL    = 7;

  // timing: rtc_transfer_period, least time, rounded up to cycles
  localparam int unsigned      CLK_NS      = 10;
  localparam int unsigned      RTC_XFER_NS = 1000;
  localparam int unsigned      XFER_CYC    = (RTC_XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned      XFER_W      = 8;

  // whole registered state of the core
  typedef struct packed {
    logic [7:0]        century;
    logic              watchdog_fired_flag;
    logic              alarm_hit_flag;
    logic              power_fail_flag;
    logic              osc_failure_flag;
    logic              cal_out_en;
    logic              write_freeze;
    logic              read_freeze;
    logic [XFER_W-1:0] xfer_cnt;
    logic              xfer_busy;
    logic              xfer_done;
    logic [31:0]       prdata;
  } rcf_state_s;

endpackage

// *** logic/rcf_alarm_match.sv ***
// alarm comparator: seconds, minutes and hours with per-field match-select
module rcf_alarm_match
  import rcf_pkg::*;
(
  input  wire logic [7:0] alarm_sec,
  input  wire logic [7:0] alarm_min,
  input  wire logic [7:0] alarm_hour,
  input  wire logic [6:0] now_sec,
  input  wire logic [6:0] now_min,
  input  wire logic [6:0] now_hour,
  output logic            match
);

  // a field hits when ignored or when its bcd value is equal
  function automatic logic field_hit(input logic [7:0] alm, input logic [6:0] now);
    field_hit = alm[ALM_MSEL] | (alm[6:0] == now);
  endfunction

  // all fields must hit; all ignored gives a match every tick
  always_comb begin
    match = field_hit(alarm_sec, now_sec)
          & field_hit(alarm_min, now_min)
          & field_hit(alarm_hour, now_hour);
  end

endmodule

// *** logic/rcf_core.sv ***
// century and status-flags register block behind an apb slave
module rcf_core
  import rcf_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // power monitor
  input  wire logic               below_switch_threshold,
  // oscillator and watchdog events
  input  wire logic               osc_fail_event,
  input  wire logic               watchdog_expired,
  // alarm registers and current time
  input  wire logic               second_tick,
  input  wire logic [7:0]         alarm_sec,
  input  wire logic [7:0]         alarm_min,
  input  wire logic [7:0]         alarm_hour,
  input  wire logic [6:0]         now_sec,
  input  wire logic [6:0]         now_min,
  input  wire logic [6:0]         now_hour,
  // year counter rollover into the century
  input  wire logic               century_carry,
  // to timekeeping counters
  output logic [7:0]              century,
  output logic                    cal_out_en,
  output logic                    write_freeze,
  output logic                    read_freeze,
  output logic                    xfer_busy,
  output logic                    base_time_load
);

  rcf_state_s q;
  rcf_state_s d;

  logic       alarm_match;
  logic       setup_ph;
  logic       access_ph;
  logic       hit_flags;
  logic       hit_cent;
  logic       wr_flags;
  logic       wr_cent;
  logic       rd_flags;
  logic [7:0] flags_view;

  // word-aligned address decode, shared by both registers
  function automatic logic addr_hit(input logic [PADDR_W-1:0] a, input logic [16:0] base);
    addr_hit = (a == base[PADDR_W-1:0]);
  endfunction

  // a byte is legal bcd when both nibbles are 0..9
  function automatic logic bcd_ok(input logic [7:0] v);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9);
  endfunction

  // bcd increment with wrap from 99 back to 00
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] >= 4'h9) begin
      r[3:0] = 4'h0;
      r[7:4] = (v[7:4] >= 4'h9) ? 4'h0 : v[7:4] + 4'h1;
    end else begin
      r[3:0] = v[3:0] + 4'h1;
    end
    bcd_inc = r;
  endfunction

  rcf_alarm_match u_alarm (
    .alarm_sec  (alarm_sec),
    .alarm_min  (alarm_min),
    .alarm_hour (alarm_hour),
    .now_sec    (now_sec),
    .now_min    (now_min),
    .now_hour   (now_hour),
    .match      (alarm_match)
  );

  // apb phase and target decode
  always_comb begin
    setup_ph  = psel & ~penable;
    access_ph = psel & penable;
    hit_flags = addr_hit(paddr, ADDR_FLAGS);
    hit_cent  = addr_hit(paddr, ADDR_CENT);
    wr_flags  = access_ph & pwrite & hit_flags & pstrb[0];
    wr_cent   = access_ph & pwrite & hit_cent & pstrb[0];
    rd_flags  = access_ph & ~pwrite & hit_flags;
  end

  // flags byte as software sees it; bit 3 reads zero
  always_comb begin
    flags_view            = 8'h00;
    flags_view[FLG_WDOG]    = q.watchdog_fired_flag;
    flags_view[FLG_ALARM]   = q.alarm_hit_flag;
    flags_view[FLG_PWRFAIL] = q.power_fail_flag;
    flags_view[FLG_OSCFAIL] = q.osc_failure_flag;
    flags_view[FLG_CAL]     = q.cal_out_en;
    flags_view[FLG_WFRZ]    = q.write_freeze;
    flags_view[FLG_RFRZ]    = q.read_freeze;
  end

  // next-state logic for the whole block
  always_comb begin
    d           = q;
    d.xfer_done = 1'b0;

    // read data captured in setup so the access phase needs no wait
    if (setup_ph && !pwrite) begin
      if (hit_flags) begin
        d.prdata = {24'h000000, flags_view};
      end else if (hit_cent) begin
        d.prdata = {24'h000000, q.century};
      end else begin
        d.prdata = 32'h0000_0000;
      end
    end

    // read clears only the bits that were returned, so a flag raised
    // between setup and access is not lost unseen
    if (rd_flags) begin
      if (q.prdata[FLG_PWRFAIL]) begin
        d.power_fail_flag = 1'b0;
      end
      if (q.prdata[FLG_ALARM]) begin
        d.alarm_hit_flag = 1'b0;
      end
      if (q.prdata[FLG_WDOG]) begin
        d.watchdog_fired_flag = 1'b0;
      end
    end

    // software-writable flag bits; status bits other than osc fail ignore writes
    if (wr_flags) begin
      d.cal_out_en   = pwdata[FLG_CAL];
      d.write_freeze = pwdata[FLG_WFRZ];
      d.read_freeze  = pwdata[FLG_RFRZ];
      if (!pwdata[FLG_OSCFAIL]) begin
        d.osc_failure_flag = 1'b0;
      end
    end

    // century: host write wins over a rollover in the same cycle;
    // a non-bcd byte is dropped to keep the range 0..99
    if (wr_cent) begin
      if (bcd_ok(pwdata[7:0])) begin
        d.century = pwdata[7:0];
      end
    end else if (century_carry) begin
      d.century = bcd_inc(q.century);
    end

    // hardware events set last so that a set beats a clear
    if (below_switch_threshold) begin
      d.power_fail_flag = 1'b1;
    end
    if (second_tick && alarm_match) begin
      d.alarm_hit_flag = 1'b1;
    end
    if (watchdog_expired) begin
      d.watchdog_fired_flag = 1'b1;
    end
    if (osc_fail_event) begin
      d.osc_failure_flag = 1'b1;
    end

    // releasing write freeze starts the base-time transfer; the load
    // strobe fires once the transfer period has run out
    if (wr_flags && q.write_freeze && !pwdata[FLG_WFRZ]) begin
      d.xfer_busy = 1'b1;
      d.xfer_cnt  = XFER_W'(XFER_CYC);
    end else if (q.xfer_busy) begin
      if (q.xfer_cnt <= XFER_W'(1)) begin
        d.xfer_busy = 1'b0;
        d.xfer_done = 1'b1;
        d.xfer_cnt  = '0;
      end else begin
        d.xfer_cnt = q.xfer_cnt - XFER_W'(1);
      end
    end
  end

  // single state register; reset stands for power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                     <= '0;
      q.century             <= CENTURY_RST;
      q.power_fail_flag     <= 1'b0;
      q.alarm_hit_flag      <= 1'b0;
      q.watchdog_fired_flag <= 1'b0;
      q.cal_out_en          <= CTRL_RST;
      q.write_freeze        <= CTRL_RST;
      q.read_freeze         <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // apb answers: zero wait states, error on unmapped word
  always_comb begin
    pready  = 1'b1;
    prdata  = q.prdata;
    pslverr = access_ph & ~(hit_flags | hit_cent);
  end

  // outputs toward the counters all come from flops
  always_comb begin
    century        = q.century;
    cal_out_en     = q.cal_out_en;
    write_freeze   = q.write_freeze;
    read_freeze    = q.read_freeze;
    xfer_busy      = q.xfer_busy;
    base_time_load = q.xfer_done;
  end

endmodule

// *** testbench/rcf_core_monitor.sv ***
// concurrent checks on the century and flags block ports
module rcf_core_monitor
  import rcf_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic               below_switch_threshold,
  input wire logic               century_carry,
  input wire logic [7:0]         century,
  input wire logic               write_freeze,
  input wire logic               xfer_busy,
  input wire logic               base_time_load
);
  timeunit 1ns;
  timeprecision 1ns;
  // the load pulse is sampled one edge after the last count step
  localparam int GAP = XFER_CYC - 7;
  logic acc;
  logic hit;
  logic cwr;
  // access phase and decode helpers
  assign acc = psel && penable;
  assign hit = (paddr == ADDR_FLAGS) || (paddr == ADDR_CENT);
  assign cwr = acc && pwrite && pstrb[0] && (paddr == ADDR_CENT);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bcd step with wrap at 99
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == 8'h99) return 8'h00;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return {v[7:4], v[3:0] + 4'h1};
  endfunction
  sequence s_release;
    acc && pwrite && pstrb[0] && paddr == ADDR_FLAGS && write_freeze && !pwdata[FLG_WFRZ];
  endsequence
  sequence s_quiet;
    (!base_time_load)[*8];
  endsequence
  a_cent_bcd_range: assert property (century[3:0] <= 4'h9 && century[7:4] <= 4'h9)
    else $error("century digit out of range");
  a_cent_carry_step: assert property (century_carry && !cwr |=>
    century == bcd_inc($past(century))) else $error("century carry step wrong");
  a_cent_write_take: assert property (cwr && pwdata[3:0] <= 4'h9 && pwdata[7:4] <= 4'h9
    |=> century == $past(pwdata[7:0])) else $error("century write lost");
  a_pf_read_seen: assert property (acc && !pwrite && paddr == ADDR_FLAGS
    && $past(below_switch_threshold, 2) && $past(below_switch_threshold, 3)
    |-> prdata[FLG_PWRFAIL]) else $error("power fail flag not set");
  a_xfer_busy_start: assert property (s_release |=> xfer_busy)
    else $error("transfer did not start");
  a_xfer_load_time: assert property (s_release |-> ##1 s_quiet ##GAP base_time_load)
    else $error("load pulse timing wrong");
  a_load_one_cycle: assert property (base_time_load |=> !base_time_load)
    else $error("load pulse too long");
  a_unmapped_err: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
endmodule

bind rcf_core rcf_core_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pslverr, .below_switch_threshold, .century_carry, .century,
  .write_freeze, .xfer_busy, .base_time_load);

// *** testbench/rcf_host.sv ***
// apb host model standing on the far side of the register block
module rcf_host
  import rcf_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               pready,
  input  wire logic [31:0]        prdata,
  input  wire logic               pslverr,
  input  wire logic               xfer_busy,
  output logic                    psel,
  output logic                    penable,
  output logic                    pwrite,
  output logic [PADDR_W-1:0]      paddr,
  output logic [31:0]             pwdata,
  output logic [3:0]              pstrb
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // one transfer; request held until pready is seen at a rising edge, for at most 16 edges, answer taken there
  task automatic xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge pclk);
      rd = prdata;
      err = pslverr;
      ok = (pready === 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // new base time reaches the store only once the transfer period is over
  task automatic settle(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 4 * XFER_CYC && !ok; i++) begin
      @(negedge pclk);
      ok = (xfer_busy === 1'b0);
    end
  endtask
endmodule

// *** testbench/test_rcf_core.sv ***
// self-checking bench for the century and flags block
module test_rcf_core
  import rcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic               pclk = 1'b0, presetn = 1'b0, below = 1'b0, wdx = 1'b0;
  logic               tick = 1'b0, carry = 1'b0, ok;
  logic               psel, penable, pwrite, pready, pslverr, err, wfrz, busy, load;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         pstrb;
  logic [7:0]         a_sec = 8'h15;
  logic [6:0]         n_sec = 7'h15;
  int                 n_errors = 0, checked = 0;
  always #5 pclk = ~pclk;
  rcf_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .below_switch_threshold(below), .osc_fail_event(1'b0),
    .watchdog_expired(wdx), .second_tick(tick), .alarm_sec(a_sec), .alarm_min(8'h80),
    .alarm_hour(8'h80), .now_sec(n_sec), .now_min(7'h00), .now_hour(7'h00),
    .century_carry(carry), .century(), .cal_out_en(), .write_freeze(wfrz),
    .read_freeze(), .xfer_busy(busy), .base_time_load(load));
  rcf_host u_host (.pclk, .pready, .prdata, .pslverr, .xfer_busy(busy), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a hung bus ends the run at once
  task automatic bus(input logic w, input logic [PADDR_W-1:0] a, input logic [7:0] d);
    u_host.xfer(w, a, {24'h0, d}, rd, err, ok);
    if (!ok) begin
      n_errors++;
      conclude();
    end
  endtask
  // one-cycle pulse: 0 carry, 1 watchdog, 2 second tick
  task automatic pulse(input int sel);
    @(posedge pclk);
    case (sel)
      0: carry <= 1'b1;
      1: wdx <= 1'b1;
      default: tick <= 1'b1;
    endcase
    @(posedge pclk);
    carry <= 1'b0;
    wdx <= 1'b0;
    tick <= 1'b0;
  endtask
  task automatic t_century();
    logic [7:0] wv[4] = '{8'h99, 8'h5A, 8'h09, 8'h42};
    logic [7:0] ev[4] = '{8'h00, 8'h01, 8'h10, 8'h42};
    bus(1'b0, ADDR_CENT, 8'h00);
    chk("century reset", rd, {24'h0, CENTURY_RST});
    // non-bcd write is dropped, carry still steps
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CENT, wv[i]);
      if (wv[i] != ev[i]) pulse(0);
      bus(1'b0, ADDR_CENT, 8'h00);
      chk("century", rd, {24'h0, ev[i]});
    end
  endtask
  task automatic t_flags();
    bus(1'b0, ADDR_FLAGS, 8'h00);
    chk("flags reset", rd, 32'h0);
    @(posedge pclk) below <= 1'b1;
    repeat (3) @(posedge pclk);
    below <= 1'b0;
    pulse(1);
    pulse(2);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    chk("flags set", rd, 32'hE0);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    chk("flags cleared", rd, 32'h0);
    bus(1'b1, ADDR_FLAGS, 8'hE0);
    n_sec <= 7'h16;
    pulse(2);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    chk("no match", rd, 32'h0);
    a_sec <= 8'h95;
    pulse(2);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    chk("field ignored", rd, 32'h40);
  endtask
  task automatic t_xfer();
    int k;
    bus(1'b1, ADDR_FLAGS, 8'h07);
    // outputs settle after the access edge that launches them
    @(negedge pclk);
    chk("freeze", {31'h0, wfrz}, 32'h1);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    chk("ctrl readback", rd, 32'h07);
    bus(1'b1, ADDR_FLAGS, 8'h00);
    @(negedge pclk);
    chk("busy", {31'h0, busy}, 32'h1);
    k = 0;
    while (k < 2 * XFER_CYC && load !== 1'b1) begin
      @(negedge pclk);
      k++;
    end
    chk("load delay", k, XFER_CYC);
    u_host.settle(ok);
    chk("settled", {31'h0, ok}, 32'h1);
  endtask
  task automatic t_unmapped();
    bus(1'b1, ADDR_CENT + 17'h4, 8'h11);
    chk("wr err", {31'h0, err}, 32'h1);
    bus(1'b0, ADDR_CENT + 17'h4, 8'h00);
    chk("rd err", {31'h0, err}, 32'h1);
    chk("rd data", rd, 32'h0);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_century();
    t_flags();
    t_xfer();
    t_unmapped();
    conclude();
  end
endmodule
